/* core/otp_store.sv */
`timescale 1ns/100ps
// Contract
// - gain read-out spans 0 to 255 in 5V supply mode.
// - gain read-out is limited to 0 to 128 in 3.3V mode.
// - magnitude from the angle engine is readable, read-only.
// - fuse programming happens only through register writes on the serial port.
// - zero-position burn succeeds at most three times.
// - burn counter register shows how many zero burns happened.
// - configuration burn succeeds only once.
// - zero offset shifts the angle onto an electrical transition position.
// - writing 0x01, 0x11, 0x10 reloads fuse contents into the registers.
// - register commands reach the outputs no earlier than 1 ms later.
// - resolution field sets quadrature positions per revolution.
// - at reset registers load from fuses; unprogrammed bits read zero.
// - code 0 gives 8 positions, doubling to 1024, others give 2048.
module otp_store #(
  parameter int SETTLE_CYCLES = otp_store_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // blanks the fuse array, as on an unprogrammed part
  input wire logic otp_clear,
  // register port behind the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // measurement inputs
  input wire logic [11:0] raw_angle,
  input wire logic [11:0] magnitude,
  input wire logic [7:0] gain_in,
  input wire logic supply_3v3,
  input wire logic magnet_present,
  input wire logic magnet_low,
  input wire logic magnet_high,
  // settings as seen by the rest of the sensor
  output logic [11:0] angle_out,
  output logic [13:0] configuration_word,
  output logic [7:0] push_threshold,
  output logic [11:0] positions_per_rev
);
  // ==========================================================
  // state
  logic [11:0] fuse_zero_q, fuse_zero_d;
  logic [13:0] fuse_configuration_word_q, fuse_configuration_word_d;
  logic [3:0] fuse_res_q, fuse_res_d;
  logic [7:0] fuse_push_q, fuse_push_d;
  logic [1:0] zero_burn_count_q, zero_burn_count_d;
  logic configuration_word_burned_q, configuration_word_burned_d;
  logic [11:0] zero_offset_q, zero_offset_d;
  logic [13:0] configuration_word_q, configuration_word_d;
  logic [3:0] quadrature_resolution_q, quadrature_resolution_d;
  logic [7:0] push_q, push_d;
  logic [11:0] zero_act_q, zero_act_d;
  logic [13:0] configuration_word_act_q, configuration_word_act_d;
  logic [3:0] res_act_q, res_act_d;
  logic [7:0] push_act_q, push_act_d;
  logic [otp_store_pkg::SETTLE_W-1:0] settle_q, settle_d;
  logic pending_q, pending_d;
  otp_store_pkg::load_state_t load_q, load_d;
  logic [7:0] rdata_q, rdata_d;
  logic [11:0] angle_q, angle_d;
  logic [7:0] gain_rep;
  logic [11:0] pos_q, pos_d;
  logic cmd_wr;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    fuse_zero_d = fuse_zero_q;
    fuse_configuration_word_d = fuse_configuration_word_q;
    fuse_res_d = fuse_res_q;
    fuse_push_d = fuse_push_q;
    zero_burn_count_d = zero_burn_count_q;
    configuration_word_burned_d = configuration_word_burned_q;
    zero_offset_d = zero_offset_q;
    configuration_word_d = configuration_word_q;
    quadrature_resolution_d = quadrature_resolution_q;
    push_d = push_q;
    load_d = load_q;
    cmd_wr = reg_wr && (reg_addr == otp_store_pkg::ADDR_BURN_CMD);
    if (reg_wr)
    begin
      unique case (reg_addr)
        otp_store_pkg::ADDR_ZERO_HI: zero_offset_d[11:8] = reg_wdata[3:0];
        otp_store_pkg::ADDR_ZERO_LO: zero_offset_d[7:0] = reg_wdata;
        otp_store_pkg::ADDR_CONFIGURATION_WORD_HI:
          configuration_word_d[13:8] = reg_wdata[5:0] & otp_store_pkg::CONFIGURATION_WORD_MASK[13:8];
        otp_store_pkg::ADDR_CONFIGURATION_WORD_LO:
          configuration_word_d[7:0] = reg_wdata & otp_store_pkg::CONFIGURATION_WORD_MASK[7:0];
        otp_store_pkg::ADDR_RESOLUTION: quadrature_resolution_d = reg_wdata[3:0];
        otp_store_pkg::ADDR_PUSH_THR: push_d = reg_wdata;
        default: ;
      endcase
    end
    if (cmd_wr)
    begin
      load_d = otp_store_pkg::LOAD_IDLE;
      // a refused burn changes neither fuses nor counter
      if (reg_wdata == otp_store_pkg::CMD_BURN_ZERO && magnet_present
          && zero_burn_count_q != otp_store_pkg::ZERO_BURN_LIMIT)
      begin
        fuse_zero_d = zero_offset_q;
        zero_burn_count_d = zero_burn_count_q + 2'h1;
      end
      if (reg_wdata == otp_store_pkg::CMD_BURN_CONFIGURATION_WORD && !configuration_word_burned_q)
      begin
        fuse_configuration_word_d = configuration_word_q;
        fuse_res_d = quadrature_resolution_q;
        fuse_push_d = push_q;
        configuration_word_burned_d = 1'b1;
      end
      // reload happens only on the exact three-write sequence
      if (reg_wdata == otp_store_pkg::CMD_LOAD_1)
        load_d = otp_store_pkg::LOAD_GOT1;
      else if (reg_wdata == otp_store_pkg::CMD_LOAD_2 && load_q == otp_store_pkg::LOAD_GOT1)
        load_d = otp_store_pkg::LOAD_GOT2;
      else if (reg_wdata == otp_store_pkg::CMD_LOAD_3 && load_q == otp_store_pkg::LOAD_GOT2)
      begin
        zero_offset_d = fuse_zero_q;
        configuration_word_d = fuse_configuration_word_q;
        quadrature_resolution_d = fuse_res_q;
        push_d = fuse_push_q;
      end
    end
    if (otp_clear)
    begin
      fuse_zero_d = '0;
      fuse_configuration_word_d = '0;
      fuse_res_d = '0;
      fuse_push_d = '0;
      zero_burn_count_d = '0;
      configuration_word_burned_d = 1'b0;
    end
  end

  // ==========================================================
  // settle timer: the outputs follow the registers 1 ms after the last command
  always_comb
  begin
    settle_d = settle_q;
    pending_d = pending_q;
    zero_act_d = zero_act_q;
    configuration_word_act_d = configuration_word_act_q;
    res_act_d = res_act_q;
    push_act_d = push_act_q;
    if (reg_wr)
    begin
      // restarting on every write keeps a half-written setting off the outputs
      settle_d = otp_store_pkg::SETTLE_W'(SETTLE_CYCLES - 1);
      pending_d = 1'b1;
    end
    else if (pending_q && settle_q != '0)
      settle_d = settle_q - 1'b1;
    else if (pending_q)
    begin
      pending_d = 1'b0;
      zero_act_d = zero_offset_q;
      configuration_word_act_d = configuration_word_q;
      res_act_d = quadrature_resolution_q;
      push_act_d = push_q;
    end
  end

  // ==========================================================
  // outputs and read-back
  always_comb
  begin
    // gain saturates at the 3.3V ceiling
    gain_rep = (supply_3v3 && gain_in > otp_store_pkg::GAIN_MAX_3V3)
      ? otp_store_pkg::GAIN_MAX_3V3 : gain_in;
    // subtracting the offset puts zero on a transition position
    angle_d = raw_angle - zero_act_q;
    pos_d = (res_act_q <= otp_store_pkg::RES_CODE_MAX)
      ? (otp_store_pkg::RES_BASE << res_act_q) : otp_store_pkg::RES_TOP;
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      unique case (reg_addr)
        otp_store_pkg::ADDR_BURN_COUNT: rdata_d = {6'h00, zero_burn_count_q};
        otp_store_pkg::ADDR_ZERO_HI: rdata_d = {4'h0, zero_offset_q[11:8]};
        otp_store_pkg::ADDR_ZERO_LO: rdata_d = zero_offset_q[7:0];
        otp_store_pkg::ADDR_CONFIGURATION_WORD_HI: rdata_d = {2'h0, configuration_word_q[13:8]};
        otp_store_pkg::ADDR_CONFIGURATION_WORD_LO: rdata_d = configuration_word_q[7:0];
        otp_store_pkg::ADDR_RESOLUTION: rdata_d = {4'h0, quadrature_resolution_q};
        otp_store_pkg::ADDR_PUSH_THR: rdata_d = push_q;
        otp_store_pkg::ADDR_STATUS:
        begin
          rdata_d = 8'h00;
          rdata_d[otp_store_pkg::STATUS_MD_BIT] = magnet_present;
          rdata_d[otp_store_pkg::STATUS_ML_BIT] = magnet_low;
          rdata_d[otp_store_pkg::STATUS_MH_BIT] = magnet_high;
        end
        otp_store_pkg::ADDR_RAW_HI: rdata_d = {4'h0, raw_angle[11:8]};
        otp_store_pkg::ADDR_RAW_LO: rdata_d = raw_angle[7:0];
        otp_store_pkg::ADDR_ANGLE_HI: rdata_d = {4'h0, angle_q[11:8]};
        otp_store_pkg::ADDR_ANGLE_LO: rdata_d = angle_q[7:0];
        otp_store_pkg::ADDR_GAIN: rdata_d = gain_rep;
        otp_store_pkg::ADDR_MAG_HI: rdata_d = {4'h0, magnitude[11:8]};
        otp_store_pkg::ADDR_MAG_LO: rdata_d = magnitude[7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers; the fuse array survives sys_rst, only otp_clear blanks it
  always_ff @(posedge clk)
  begin
    fuse_zero_q <= fuse_zero_d;
    fuse_configuration_word_q <= fuse_configuration_word_d;
    fuse_res_q <= fuse_res_d;
    fuse_push_q <= fuse_push_d;
    zero_burn_count_q <= zero_burn_count_d;
    configuration_word_burned_q <= configuration_word_burned_d;
    if (sys_rst)
    begin
      // power-up copy of the fuses; blank fuses read zero
      zero_offset_q <= fuse_zero_q;
      configuration_word_q <= fuse_configuration_word_q;
      quadrature_resolution_q <= fuse_res_q;
      push_q <= fuse_push_q;
      zero_act_q <= fuse_zero_q;
      configuration_word_act_q <= fuse_configuration_word_q;
      res_act_q <= fuse_res_q;
      push_act_q <= fuse_push_q;
      settle_q <= '0;
      pending_q <= 1'b0;
      load_q <= otp_store_pkg::LOAD_IDLE;
      rdata_q <= 8'h00;
      angle_q <= 12'h000;
      pos_q <= otp_store_pkg::RES_BASE;
    end
    else
    begin
      zero_offset_q <= zero_offset_d;
      configuration_word_q <= configuration_word_d;
      quadrature_resolution_q <= quadrature_resolution_d;
      push_q <= push_d;
      zero_act_q <= zero_act_d;
      configuration_word_act_q <= configuration_word_act_d;
      res_act_q <= res_act_d;
      push_act_q <= push_act_d;
      settle_q <= settle_d;
      pending_q <= pending_d;
      load_q <= load_d;
      rdata_q <= rdata_d;
      angle_q <= angle_d;
      pos_q <= pos_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign angle_out = angle_q;
  assign configuration_word = configuration_word_act_q;
  assign push_threshold = push_act_q;
  assign positions_per_rev = pos_q;
endmodule : otp_store

/* core/otp_store_pkg.sv */
package otp_store_pkg;
  // register offsets on the device register port
  localparam logic [7:0] ADDR_BURN_COUNT = 8'h00;
  localparam logic [7:0] ADDR_ZERO_HI = 8'h01;
  localparam logic [7:0] ADDR_ZERO_LO = 8'h02;
  localparam logic [7:0] ADDR_CONFIGURATION_WORD_HI = 8'h07;
  localparam logic [7:0] ADDR_CONFIGURATION_WORD_LO = 8'h08;
  localparam logic [7:0] ADDR_RESOLUTION = 8'h09;
  localparam logic [7:0] ADDR_PUSH_THR = 8'h0a;
  localparam logic [7:0] ADDR_STATUS = 8'h0b;
  localparam logic [7:0] ADDR_RAW_HI = 8'h0c;
  localparam logic [7:0] ADDR_RAW_LO = 8'h0d;
  localparam logic [7:0] ADDR_ANGLE_HI = 8'h0e;
  localparam logic [7:0] ADDR_ANGLE_LO = 8'h0f;
  localparam logic [7:0] ADDR_GAIN = 8'h1a;
  localparam logic [7:0] ADDR_MAG_HI = 8'h1b;
  localparam logic [7:0] ADDR_MAG_LO = 8'h1c;
  localparam logic [7:0] ADDR_BURN_CMD = 8'hff;
  // burn command codes
  localparam logic [7:0] CMD_BURN_ZERO = 8'h80;
  localparam logic [7:0] CMD_BURN_CONFIGURATION_WORD = 8'h40;
  localparam logic [7:0] CMD_LOAD_1 = 8'h01;
  localparam logic [7:0] CMD_LOAD_2 = 8'h11;
  localparam logic [7:0] CMD_LOAD_3 = 8'h10;
  // field layout
  localparam logic [13:0] CONFIGURATION_WORD_MASK = 14'h3f0f;
  localparam logic [1:0] ZERO_BURN_LIMIT = 2'h3;
  localparam logic [7:0] GAIN_MAX_3V3 = 8'h80;
  localparam int STATUS_MD_BIT = 5;
  localparam int STATUS_ML_BIT = 4;
  localparam int STATUS_MH_BIT = 3;
  localparam logic [3:0] RES_CODE_MAX = 4'h7;
  localparam logic [11:0] RES_BASE = 12'h008;
  localparam logic [11:0] RES_TOP = 12'h800;
  // settle time before a command shows at the outputs
  localparam int SETTLE_TIME_US = 1000;
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
  localparam int SETTLE_W = 20;

  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b00,
    LOAD_GOT1 = 2'b01,
    LOAD_GOT2 = 2'b10
  } load_state_t;
endpackage : otp_store_pkg

/* verification/otp_store_asserts.sv */
`timescale 1ns/100ps
// =====
// register reads and settled outputs
module otp_store_asserts #(
  parameter int SETTLE_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic otp_clear,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // sensor levels
  input wire logic [11:0] magnitude,
  input wire logic [7:0] gain_in,
  input wire logic supply_3v3,
  input wire logic magnet_present,
  // settled outputs
  input wire logic [13:0] configuration_word,
  input wire logic [7:0] push_threshold,
  input wire logic [11:0] positions_per_rev
);
  logic [19:0] quiet_q;
  logic [19:0] quiet_d;
  logic rd_gain;
  logic [7:0] gain_cap;
  assign rd_gain = reg_rd && reg_addr == otp_store_pkg::ADDR_GAIN;
  assign gain_cap = gain_in > 8'h80 ? 8'h80 : gain_in;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles since last write; saturates so a fresh reset never arms the quiet check
  always_comb
    quiet_d = reg_wr ? 20'h0 : quiet_q + {19'h0, quiet_q != 20'hfffff};
  always_ff @(posedge clk)
    quiet_q <= sys_rst ? 20'hfffff : quiet_d;
  // last burn count read back; only a blanked part may show a lower one later
  logic rd_count_q;
  logic [7:0] count_seen_q;
  always_ff @(posedge clk)
  begin
    rd_count_q <= reg_rd && reg_addr == otp_store_pkg::ADDR_BURN_COUNT;
    if (otp_clear)
      count_seen_q <= 8'h00;
    else if (rd_count_q)
      count_seen_q <= reg_rdata;
  end
  a_gain_full: assert property (rd_gain && !supply_3v3 |=> reg_rdata == $past(gain_in))
    else $error("gain read differs from input");
  a_gain_clip: assert property (rd_gain && supply_3v3 |=> reg_rdata == $past(gain_cap))
    else $error("gain read not clipped");
  a_mag_low: assert property (reg_rd && reg_addr == otp_store_pkg::ADDR_MAG_LO
    |=> reg_rdata == $past(magnitude[7:0])) else $error("magnitude read wrong");
  a_count_max: assert property (reg_rd && reg_addr == otp_store_pkg::ADDR_BURN_COUNT
    |=> reg_rdata <= 8'h03 && reg_rdata >= count_seen_q) else $error("burn count out of range");
  a_status_md: assert property (reg_rd && reg_addr == otp_store_pkg::ADDR_STATUS
    |=> reg_rdata[5] == $past(magnet_present)) else $error("magnet bit wrong");
  a_cmd_zero: assert property (reg_rd && reg_addr == otp_store_pkg::ADDR_BURN_CMD
    |=> reg_rdata == 8'h00) else $error("command register readable");
  a_settle_quiet: assert property (!reg_wr && quiet_q != 0 && quiet_q < SETTLE_CYCLES
    |-> $stable({configuration_word, push_threshold, positions_per_rev}))
    else $error("output changed before settle time");
  a_res_power: assert property ($onehot(positions_per_rev) && positions_per_rev >= 12'h008)
    else $error("positions not a power of two");
endmodule : otp_store_asserts

bind otp_store otp_store_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_otp_store_asserts (
  .clk(clk),
  .sys_rst(sys_rst),
  .otp_clear(otp_clear),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .magnitude(magnitude),
  .gain_in(gain_in),
  .supply_3v3(supply_3v3),
  .magnet_present(magnet_present),
  .configuration_word(configuration_word),
  .push_threshold(push_threshold),
  .positions_per_rev(positions_per_rev)
);

/* verification/otp_host.sv */
`timescale 1ns/100ps
// =====
// host on the register port; strobes change only at falling edges
module otp_host (
  // clock
  input wire logic clk,
  // register port
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  input wire logic [7:0] reg_rdata
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    // released data is inverted so a stale value cannot pass as good
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
  task automatic reload;
    wr(otp_store_pkg::ADDR_BURN_CMD, otp_store_pkg::CMD_LOAD_1);
    wr(otp_store_pkg::ADDR_BURN_CMD, otp_store_pkg::CMD_LOAD_2);
    wr(otp_store_pkg::ADDR_BURN_CMD, otp_store_pkg::CMD_LOAD_3);
  endtask : reload
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
endmodule : otp_host

/* verification/test_otp_store.sv */
`timescale 1ns/100ps
// =====
// bench: host model drives the register port, sensor levels come from here
module test_otp_store;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic otp_clear = 1'b1;
  logic [11:0] raw_angle = 12'h000;
  logic [11:0] magnitude = 12'habc;
  logic [7:0] gain_in = 8'hff;
  logic supply_3v3 = 1'b0;
  logic magnet_present = 1'b0;
  logic magnet_low = 1'b0;
  logic magnet_high = 1'b1;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, push_threshold;
  logic [11:0] angle_out, positions_per_rev;
  logic [13:0] configuration_word;
  int num_errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  otp_store #(.SETTLE_CYCLES(SETTLE)) u_otp_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .otp_clear(otp_clear),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .raw_angle(raw_angle),
    .magnitude(magnitude),
    .gain_in(gain_in),
    .supply_3v3(supply_3v3),
    .magnet_present(magnet_present),
    .magnet_low(magnet_low),
    .magnet_high(magnet_high),
    .angle_out(angle_out),
    .configuration_word(configuration_word),
    .push_threshold(push_threshold),
    .positions_per_rev(positions_per_rev)
  );
  otp_host u_otp_host (
    .clk(clk),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );
  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    u_otp_host.rd(a, rd_v);
    check(what, {6'h0, exp}, {6'h0, rd_v});
  endtask : rdchk
  task automatic finish_test;
    $display("mismatches %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic t_levels;
    rdchk(otp_store_pkg::ADDR_GAIN, 8'hff, "gain");
    supply_3v3 = 1'b1;
    rdchk(otp_store_pkg::ADDR_GAIN, 8'h80, "gain clip");
    gain_in = 8'h7f;
    rdchk(otp_store_pkg::ADDR_GAIN, 8'h7f, "gain low");
    rdchk(otp_store_pkg::ADDR_MAG_HI, 8'h0a, "mag hi");
    rdchk(otp_store_pkg::ADDR_MAG_LO, 8'hbc, "mag lo");
    magnet_low = 1'b1;
    rdchk(otp_store_pkg::ADDR_STATUS, 8'h18, "status");
    rdchk(8'h20, 8'h00, "unmapped");
    rdchk(otp_store_pkg::ADDR_BURN_CMD, 8'h00, "command");
  endtask : t_levels
  task automatic t_res;
    logic [11:0] old;
    for (int c = 0; c < 16; c++)
    begin
      u_otp_host.wr(otp_store_pkg::ADDR_RESOLUTION, 8'(c));
      old = positions_per_rev;
      u_otp_host.hold(SETTLE - 2);
      check("early positions", old, positions_per_rev);
      u_otp_host.hold(4);
      check("positions", c < 8 ? 12'h008 << c : 12'h800, positions_per_rev);
    end
  endtask : t_res
  task automatic t_angle;
    raw_angle = 12'h100;
    rdchk(otp_store_pkg::ADDR_RAW_HI, 8'h01, "raw hi");
    u_otp_host.wr(otp_store_pkg::ADDR_ZERO_HI, 8'h01);
    u_otp_host.wr(otp_store_pkg::ADDR_ZERO_LO, 8'h23);
    u_otp_host.hold(SETTLE + 2);
    check("angle", 12'hfdd, angle_out);
    rdchk(otp_store_pkg::ADDR_ANGLE_LO, 8'hdd, "angle lo");
  endtask : t_angle
  task automatic t_burn;
    u_otp_host.wr(otp_store_pkg::ADDR_BURN_CMD, otp_store_pkg::CMD_BURN_ZERO);
    rdchk(otp_store_pkg::ADDR_BURN_COUNT, 8'h00, "count no magnet");
    magnet_present = 1'b1;
    for (int i = 1; i < 5; i++)
    begin
      u_otp_host.wr(otp_store_pkg::ADDR_ZERO_LO, 8'(i));
      u_otp_host.wr(otp_store_pkg::ADDR_BURN_CMD, otp_store_pkg::CMD_BURN_ZERO);
      u_otp_host.hold(SETTLE);
      rdchk(otp_store_pkg::ADDR_BURN_COUNT, i < 4 ? 8'(i) : 8'h03, "count");
    end
    u_otp_host.wr(otp_store_pkg::ADDR_CONFIGURATION_WORD_HI, 8'hff);
    u_otp_host.wr(otp_store_pkg::ADDR_CONFIGURATION_WORD_LO, 8'hff);
    u_otp_host.wr(otp_store_pkg::ADDR_RESOLUTION, 8'h05);
    u_otp_host.wr(otp_store_pkg::ADDR_PUSH_THR, 8'h5a);
    u_otp_host.hold(SETTLE);
    u_otp_host.wr(otp_store_pkg::ADDR_BURN_CMD, otp_store_pkg::CMD_BURN_CONFIGURATION_WORD);
    u_otp_host.hold(SETTLE);
    u_otp_host.wr(otp_store_pkg::ADDR_CONFIGURATION_WORD_HI, 8'h01);
    u_otp_host.wr(otp_store_pkg::ADDR_BURN_CMD, otp_store_pkg::CMD_BURN_CONFIGURATION_WORD);
    u_otp_host.reload();
    u_otp_host.hold(SETTLE + 2);
    check("configuration_word", 14'h3f0f, configuration_word);
    check("push", 14'h005a, {6'h0, push_threshold});
    rdchk(otp_store_pkg::ADDR_ZERO_LO, 8'h03, "zero lo");
    // working copies drift from the fuses so the restart must really reload them
    u_otp_host.wr(otp_store_pkg::ADDR_CONFIGURATION_WORD_HI, 8'h01);
    u_otp_host.wr(otp_store_pkg::ADDR_ZERO_HI, 8'h02);
    sys_rst = 1'b1;
    u_otp_host.hold(2);
    sys_rst = 1'b0;
    u_otp_host.hold(2);
    check("configuration_word restart", 14'h3f0f, configuration_word);
    check("positions restart", 14'h0100, {2'h0, positions_per_rev});
    rdchk(otp_store_pkg::ADDR_ZERO_HI, 8'h01, "zero hi restart");
    rdchk(otp_store_pkg::ADDR_BURN_COUNT, 8'h03, "count restart");
  endtask : t_burn
  initial
  begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    otp_clear = 1'b0;
    rdchk(otp_store_pkg::ADDR_BURN_COUNT, 8'h00, "blank count");
    check("blank configuration_word", 14'h0000, configuration_word);
    check("blank positions", 14'h0008, {2'h0, positions_per_rev});
    t_levels();
    t_res();
    t_angle();
    t_burn();
    finish_test();
  end
  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule : test_otp_store
